//--- obm_loader.sv
// Boot mirroring loader: copies OTP boot image into system RAM
`timescale 1ns/1ps
module obm_loader (
	// Clock and reset (ref_clk is the fast RC clock during boot)
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic        clk_en,
	// Boot triggers and crystal status (pins)
	input  wire logic        wake_req,
	input  wire logic        xtal_ready,
	input  wire logic        dev_mode,
	input  wire logic [1:0]  dev_map,
	// Software requests from the CPU side
	input  wire logic        sw_reset_req,
	input  wire logic [3:0]  ret_power_cfg,
	// OTP read port
	output logic             otp_rd,
	output logic [12:0]      otp_addr,
	input  wire logic [31:0] otp_rdata,
	// Status and control outputs
	output logic             cpu_reset,
	output logic [1:0]       remap_sel,
	output logic             clk_sel_crystal,
	output logic             debug_enable,
	output logic             mirror_busy,
	output logic             mirror_done,
	output logic             length_error,
	output logic [3:0]       ret_power_on,
	// System RAM read-back for the CPU
	input  wire logic        cpu_rd,
	input  wire logic [13:0] cpu_addr,
	output logic [31:0]      cpu_rdata
);
	typedef enum logic [2:0] {
		obm_idle, obm_rd_debug, obm_rd_len, obm_copy, obm_run
	} obm_state_type;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] wake_sync, xtal_sync, dev_sync;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wake_sync <= 2'h0;
			xtal_sync <= 2'h0;
			dev_sync  <= 2'h0;
		end else if (clk_en) begin
			wake_sync <= {wake_sync[0], wake_req};
			xtal_sync <= {xtal_sync[0], xtal_ready};
			dev_sync  <= {dev_sync[0], dev_mode};
		end
	end
	logic wake_s, xtal_s, dev_s, wake_prev;
	assign wake_s = wake_sync[1];
	assign xtal_s = xtal_sync[1];
	assign dev_s  = dev_sync[1];

	// ****************************************
	// Start-up settle
	// ****************************************
	// Pin levels mean nothing until both synchroniser stages have filled,
	// so boot versus development mode is not decided any earlier
	logic [1:0] settle;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			settle <= 2'h0;
		end else if (clk_en) begin
			settle <= {settle[0], 1'b1};
		end
	end
	wire pins_valid = settle[1];

	// ****************************************
	// Mirror sequencer
	// ****************************************
	obm_state_type state, next_state;
	// One bit wider than the OTP address so a full 8K image can be counted
	logic [13:0] word_cnt;
	logic [13:0] copy_len;
	logic        rd_pend;
	logic [12:0] rd_addr;
	obm_ram_if   ram();

	// Reject a length beyond OTP or system RAM size; a bad length copies nothing
	function automatic logic len_bad(input logic [31:0] len);
		len_bad = (len > 32'(obm_pkg::OTP_WORDS)) || (len > 32'(obm_pkg::SYSRAM_WORDS));
	endfunction

	wire start_boot = (state == obm_idle) && pins_valid && !dev_s;
	wire wake_edge  = wake_s && !wake_prev;
	wire last_word  = (word_cnt == copy_len);
	wire dbg_on     = (otp_rdata == obm_pkg::DEBUG_ON_CODE);
	wire dbg_off    = (otp_rdata == obm_pkg::DEBUG_OFF_CODE);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			obm_idle:     if (start_boot) next_state = obm_rd_debug;
			obm_rd_debug: if (rd_pend) next_state = obm_rd_len;
			obm_rd_len:   if (rd_pend) next_state = obm_copy;
			obm_copy:     if (last_word && !rd_pend) next_state = obm_run;
			obm_run:      if (wake_edge || sw_reset_req) next_state = obm_rd_debug;
		endcase
		// Development builds never mirror; a copy under way is abandoned
		if (dev_s) begin
			next_state = obm_idle;
		end
	end

	// ****************************************
	// OTP read port
	// ****************************************
	// OTP address: header words first, then image from word zero
	always_comb begin
		rd_addr = word_cnt[12:0];
		unique case (state)
			obm_rd_debug: rd_addr = obm_pkg::HDR_DEBUG_ADDR;
			obm_rd_len:   rd_addr = obm_pkg::HDR_LEN_ADDR;
			default:      rd_addr = word_cnt[12:0];
		endcase
	end

	// One read in flight at a time; the idle slot after each image read is the write slot
	wire issue = !rd_pend && ((state == obm_rd_debug) || (state == obm_rd_len)
		|| ((state == obm_copy) && !last_word));
	assign otp_rd   = issue;
	assign otp_addr = rd_addr;

	// ****************************************
	// Sequencer registers
	// ****************************************
	logic [12:0] wr_addr;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state        <= obm_idle;
			word_cnt     <= 14'h0000;
			copy_len     <= 14'h0000;
			rd_pend      <= 1'b0;
			wr_addr      <= 13'h0000;
			wake_prev    <= 1'b0;
			debug_enable <= 1'b0;
			length_error <= 1'b0;
		end else if (clk_en) begin
			state     <= next_state;
			wake_prev <= wake_s;
			rd_pend   <= issue;
			if (rd_pend && state == obm_rd_debug) begin
				debug_enable <= dbg_on || !dbg_off;
				word_cnt     <= 14'h0000;
			end
			if (rd_pend && state == obm_rd_len) begin
				length_error <= len_bad(otp_rdata);
				copy_len     <= len_bad(otp_rdata) ? 14'h0000 : otp_rdata[13:0];
			end
			if (issue && state == obm_copy) begin
				wr_addr  <= word_cnt[12:0];
				word_cnt <= word_cnt + 14'h0001;
			end
		end
	end

	// ****************************************
	// System RAM port
	// ****************************************
	// Writes land one cycle after each read, whole words
	assign ram.we    = clk_en && rd_pend && (state == obm_copy);
	assign ram.addr  = ram.we ? {1'b0, wr_addr} : cpu_addr;
	assign ram.wdata = otp_rdata;
	assign ram.rd_en = cpu_rd && !ram.we;
	assign cpu_rdata = ram.rdata;

	obm_sysram #(.WORDS(obm_pkg::SYSRAM_WORDS)) u_sysram (
		.ref_clk (ref_clk),
		.clk_en  (clk_en),
		.port    (ram.mem)
	);

	// ****************************************
	// CPU reset, remap, clock source, retention power
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cpu_reset       <= 1'b1;
			remap_sel       <= 2'h0;
			clk_sel_crystal <= 1'b0;
			ret_power_on    <= obm_pkg::RET_RESET;
		end else if (clk_en) begin
			// Boot builds hold it until the full length is mirrored; development builds follow sw_reset_req
			cpu_reset <= dev_s ? sw_reset_req : (next_state != obm_run);
			// Development builds fetch from chosen memory
			remap_sel <= dev_s ? dev_map : 2'(obm_pkg::obm_map_sysram);
			// Boot builds stay on fast RC until the copy ends and the crystal settles; development builds only wait for the crystal
			// next_state keeps a restart from run on the fast RC as well
			clk_sel_crystal <= xtal_s && (next_state == obm_run || dev_s);
			ret_power_on    <= ret_power_cfg;
		end
	end

	// ****************************************
	// Status outputs
	// ****************************************
	// Busy covers the header reads as well as the copy itself
	assign mirror_busy = (state != obm_idle) && (state != obm_run);
	assign mirror_done = (state == obm_run);
endmodule

//--- obm_pkg.sv
// Package: constants and types of the boot mirroring loader
package obm_pkg;
	// ****************************************
	// OTP organisation
	// ****************************************
	localparam int OTP_WORDS       = 8192;
	localparam int OTP_AW          = 13;
	localparam int WORD_W          = 32;
	localparam int VECTOR_WORDS    = 64;
	// Header word addresses (byte offset / 4)
	localparam logic [12:0] HDR_LEN_ADDR   = 13'h1FFE;
	localparam logic [12:0] HDR_DEBUG_ADDR = 13'h1FFF;
	localparam logic [31:0] DEBUG_ON_CODE  = 32'h00000000;
	localparam logic [31:0] DEBUG_OFF_CODE = 32'hAAAAAAAA;
	// ****************************************
	// System RAM and retention cells
	// ****************************************
	localparam int SYSRAM_BYTES    = 43008;
	localparam int SYSRAM_WORDS    = SYSRAM_BYTES / 4;
	localparam int SYSRAM_AW       = 14;
	localparam int RET_CELLS       = 4;
	localparam logic [3:0] RET_RESET = 4'hF;
	// ****************************************
	// Timing
	// ****************************************
	localparam int OTP_READ_LATENCY = 1;
	// Mirror map selects for address zero
	typedef enum logic [1:0] {
		obm_map_sysram,
		obm_map_retram,
		obm_map_rom
	} obm_map_type;
endpackage

//--- obm_ram_if.sv
// Interface: system RAM port carrying mirrored words in and CPU reads back out
`timescale 1ns/1ps
interface obm_ram_if;
	logic        we;
	logic [13:0] addr;
	logic [31:0] wdata;
	logic        rd_en;
	logic [31:0] rdata;
	modport ctrl (output we, output addr, output wdata, output rd_en, input rdata);
	modport mem  (input we, input addr, input wdata, input rd_en, output rdata);
endinterface

//--- obm_sysram.sv
// System RAM model: word memory with registered read data
`timescale 1ns/1ps
module obm_sysram #(
	parameter int WORDS = obm_pkg::SYSRAM_WORDS
) (
	// Clock
	input  wire logic ref_clk,
	input  wire logic clk_en,
	// Port
	obm_ram_if.mem    port
);
	logic [31:0] mem_array [WORDS];
	always_ff @(posedge ref_clk) begin
		if (clk_en && port.we) begin
			mem_array[port.addr] <= port.wdata;
		end
		if (clk_en && port.rd_en) begin
			port.rdata <= mem_array[port.addr];
		end
	end
endmodule

//--- obm_loader_sva.sv
// Checker: port assertions of the boot mirroring loader
`timescale 1ns/1ps
module obm_loader_sva (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        srst,
	input wire logic        clk_en,
	// Inputs
	input wire logic        dev_mode,
	input wire logic        sw_reset_req,
	input wire logic [3:0]  ret_power_cfg,
	input wire logic [31:0] otp_rdata,
	// Outputs
	input wire logic        otp_rd,
	input wire logic [12:0] otp_addr,
	input wire logic        cpu_reset,
	input wire logic        clk_sel_crystal,
	input wire logic        debug_enable,
	input wire logic        mirror_busy,
	input wire logic [3:0]  ret_power_on
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst || !clk_en);
	AST_RET: assert property (!$past(srst) |-> ret_power_on == $past(ret_power_cfg))
		else $error("retention power not copied");
	AST_GAP: assert property (otp_rd |=> !otp_rd)
		else $error("back to back otp reads");
	AST_HOLD: assert property (mirror_busy |-> cpu_reset)
		else $error("cpu released during copy");
	AST_CLK: assert property (mirror_busy |-> !clk_sel_crystal)
		else $error("crystal selected during copy");
	AST_DEV: assert property ($past(dev_mode, 3) && !$past(srst)
		&& !$past(srst, 2) && !$past(srst, 3) |-> cpu_reset == $past(sw_reset_req))
		else $error("dev reset does not follow request");
	AST_LEN: assert property (otp_rd && otp_addr == obm_pkg::HDR_DEBUG_ADDR
		|=> ##1 otp_rd && otp_addr == obm_pkg::HDR_LEN_ADDR)
		else $error("length word not read second");
	AST_VEC: assert property (otp_rd && otp_addr == obm_pkg::HDR_LEN_ADDR
		|=> ##1 ((otp_rd && otp_addr == 13'h0000) || $past(otp_rdata) == 32'h00000000
		|| $past(otp_rdata) > 32'(obm_pkg::OTP_WORDS)))
		else $error("copy does not start at word zero");
	AST_DBG: assert property ((otp_rd && otp_addr == obm_pkg::HDR_DEBUG_ADDR)
		##1 1'b1 |=> debug_enable == ($past(otp_rdata) != obm_pkg::DEBUG_OFF_CODE))
		else $error("debug enable wrong");
endmodule
bind obm_loader obm_loader_sva u_sva (.ref_clk, .srst, .clk_en, .dev_mode, .sw_reset_req,
	.ret_power_cfg, .otp_rdata, .otp_rd, .otp_addr, .cpu_reset, .clk_sel_crystal,
	.debug_enable, .mirror_busy, .ret_power_on);

//--- obm_otp_model.sv
// Partner model: OTP array answering a read one cycle later
`timescale 1ns/1ps
module obm_otp_model (
	// Clock
	input  wire logic        ref_clk,
	// Read port
	input  wire logic        otp_rd,
	input  wire logic [12:0] otp_addr,
	output logic      [31:0] otp_rdata,
	// Header contents
	input  wire logic [31:0] dbg,
	input  wire logic [31:0] len
);
	// Unprogrammed cell content; value arbitrary
	localparam logic [31:0] BLANK_WORD = 32'h00000000;
	initial otp_rdata = 32'h00000000;
	// Idle cycles invert the data so stale words never look valid
	always @(posedge ref_clk) begin
		if (otp_rd === 1'b1) begin
			otp_rdata <= (otp_addr == obm_pkg::HDR_DEBUG_ADDR) ? dbg :
				(otp_addr == obm_pkg::HDR_LEN_ADDR) ? len :
				(32'(otp_addr) == len) ? BLANK_WORD :
				{otp_addr, ~otp_addr, 6'h2A};
		end else begin
			otp_rdata <= ~otp_rdata;
		end
	end
endmodule

//--- otp_boot_mirroring_test.sv
// Testbench: boot mirroring loader
`timescale 1ns/1ps
module otp_boot_mirroring_test;
	logic        ref_clk = 0, srst = 1, dev_mode = 0, sw_reset_req = 0, cpu_rd = 0, rd_d = 0;
	logic [1:0]  dev_map = 0, remap_sel;
	logic [3:0]  ret_power_cfg = 0, ret_power_on;
	logic [12:0] otp_addr;
	logic [13:0] cpu_addr = 0;
	logic [31:0] otp_rdata, cpu_rdata, dbg = 0, len = 0, n;
	logic        otp_rd, cpu_reset, debug_enable, length_error;
	logic        wake_req = 0, xtal_ready = 0, clk_sel_crystal, mirror_busy, mirror_done;
	int          num_errors = 0, samples_checked = 0, nrd = 0, k, i, seed = 32'hE4E01270;
	logic [31:0] exp_q[$];
	initial forever #10 ref_clk = ~ref_clk;
	obm_loader DUT (.ref_clk, .srst, .clk_en(1'b1), .wake_req, .xtal_ready,
		.dev_mode, .dev_map, .sw_reset_req, .ret_power_cfg, .otp_rd, .otp_addr, .otp_rdata,
		.cpu_reset, .remap_sel, .clk_sel_crystal, .debug_enable, .mirror_busy,
		.mirror_done, .length_error, .ret_power_on, .cpu_rd, .cpu_addr, .cpu_rdata);
	obm_otp_model OTP (.ref_clk, .otp_rd, .otp_addr, .otp_rdata, .dbg, .len);
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Read data lands one cycle after the request is sampled
	always @(posedge ref_clk) begin
		rd_d <= cpu_rd;
		if (otp_rd === 1'b1) nrd <= nrd + 1;
		if (rd_d) chk(cpu_rdata, exp_q.pop_front());
	end
	initial begin
		repeat (50000) @(posedge ref_clk);
		num_errors++;
		final_report();
	end
	initial begin
		for (k = 0; k < 3; k++) begin
			n = (k == 0) ? (($random(seed) & 32'h0000000F) + 1) : (k == 1) ? 0 : 32'h00002001;
			@(posedge ref_clk);
			dbg <= (k == 0) ? obm_pkg::DEBUG_OFF_CODE : (k == 1) ? 32'h00000000 : $random(seed);
			len <= n;
			xtal_ready <= (k != 0);
			srst <= 1;
			nrd <= 0;
			repeat (8) @(posedge ref_clk);
			srst <= 0;
			i = 0;
			while (cpu_reset !== 1'b0 && i < 20000) begin
				@(negedge ref_clk);
				i++;
			end
			chk(nrd, (k == 2) ? 2 : n + 2);
			chk(32'(debug_enable), 32'(dbg !== obm_pkg::DEBUG_OFF_CODE));
			chk(32'(length_error), 32'(k == 2));
			chk(32'({mirror_done, mirror_busy, clk_sel_crystal}), 32'({2'h2, xtal_ready}));
			for (i = 0; i < ((k == 2) ? 0 : n); i++) begin
				@(posedge ref_clk);
				cpu_rd <= 1;
				cpu_addr <= i[13:0];
				exp_q.push_back({i[12:0], ~i[12:0], 6'h2A});
				@(posedge ref_clk);
				cpu_rd <= 0;
			end
			repeat (3) @(posedge ref_clk);
			$display("boot test %0d done", k);
		end
		// Wake-up from run mirrors again; the header still holds a bad length
		@(posedge ref_clk);
		wake_req <= 1;
		nrd <= 0;
		repeat (4) @(negedge ref_clk);
		chk(32'(cpu_reset), 32'h1);
		i = 0;
		while (cpu_reset !== 1'b0 && i < 200) begin
			@(negedge ref_clk);
			i++;
		end
		chk(nrd, 2);
		$display("wake test done");
		@(posedge ref_clk);
		dev_mode <= 1;
		for (k = 0; k < 3; k++) begin
			@(posedge ref_clk);
			dev_map <= k[1:0];
			sw_reset_req <= k[0];
			ret_power_cfg <= 4'($random(seed));
			repeat (3) @(negedge ref_clk);
			chk(32'(remap_sel), 32'(k));
			chk(32'(cpu_reset), 32'(k[0]));
			chk(32'(ret_power_on), 32'(ret_power_cfg));
		end
		$display("dev test done");
		final_report();
	end
endmodule
